// >>> serial_port_defines.vh
// Constants for the serial port configuration and status register.
// Assumes inclusion by serial_port_unit by its bare name.
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// ----------------------------------------------------------------------
// Register address and reset value
// ----------------------------------------------------------------------
`define CFG_ADDR 8'hA1
`define CFG_RESET 8'h07

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BUSY_BIT 7
`define MASTER_BIT 6
`define PHASE_BIT 5
`define POL_BIT 4
`define SELECTED_BIT 3
`define PIN_BIT 2
`define SHIFT_EMPTY_BIT 1
`define RX_EMPTY_BIT 0

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define SCK_HALF_CYCLES 4
`define EDGES_PER_BYTE 16

`endif

// >>> byte_buffer.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module byte_buffer #(
   parameter WIDTH = 8
) (
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [WIDTH-1:0] head_q;
   reg [WIDTH-1:0] tail_q;
   reg head_vld_q;
   reg tail_vld_q;
   wire push;
   wire pop;

   assign in_ready = ~tail_vld_q;
   assign out_valid = head_vld_q;
   assign out_data = head_q;
   assign push = in_valid & ~tail_vld_q;
   assign pop = out_ready & head_vld_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         head_q <= {WIDTH{1'b0}};
         tail_q <= {WIDTH{1'b0}};
         head_vld_q <= 1'b0;
         tail_vld_q <= 1'b0;
      end else begin
         if (pop) begin
            head_q <= tail_vld_q ? tail_q : in_data;
            head_vld_q <= tail_vld_q | push;
            tail_vld_q <= tail_vld_q & push;
            if (tail_vld_q & push) begin
               tail_q <= in_data;
            end
         end else if (push) begin
            if (head_vld_q) begin
               tail_q <= in_data;
               tail_vld_q <= 1'b1;
            end else begin
               head_q <= in_data;
               head_vld_q <= 1'b1;
            end
         end
      end
   end
endmodule

// >>> serial_port_unit.v
// Serial port with its configuration and status register.
// Assumes an 8-bit special function register port on mclk and
// asynchronous serial pins that are synchronised here.
//
// Function
// - Busy bit reads 1 during any transfer.
// - Idle clock level follows the polarity bit.
// - Slave receive-empty clears until byte is read.
// - Receive-empty reads 1 in master mode.
// - Master bit clear makes an enabled port slave.
// - Phase picks latch edge; change while disabled.
`timescale 1ns/10ps
`include "serial_port_defines.vh"
module serial_port_unit #(
   parameter HALF_DIV = `SCK_HALF_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata_q,
   input wire port_enable_bit,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output reg tx_ready_q,
   output wire [7:0] rx_data,
   output wire rx_valid,
   input wire rx_ready,
   input wire sck_in,
   output reg sck_out_q,
   output reg sck_oe_q,
   input wire sel_n_in,
   input wire mosi_in,
   input wire miso_in,
   output wire sdo_out,
   output reg mosi_oe_q,
   output reg miso_oe_q
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [3:0] meta_q;
   reg [3:0] sync_q;
   reg sck_prev_q;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_q <= 4'hF;
         sync_q <= 4'hF;
         sck_prev_q <= 1'b1;
      end else begin
         meta_q <= {sck_in, sel_n_in, mosi_in, miso_in};
         sync_q <= meta_q;
         sck_prev_q <= sync_q[3];
      end
   end
   wire sck_s = sync_q[3];
   wire sel_n_s = sync_q[2];
   wire mosi_s = sync_q[1];
   wire miso_s = sync_q[0];

   // ----------------------------------------------------------------
   // Configuration bits
   // ----------------------------------------------------------------
   // The other party must share phase and polarity; software should
   // disable the port before changing them, mid-byte writes are taken.
   localparam [7:0] RESET_VALUE = `CFG_RESET;
   reg master_mode_enable_q;
   reg clock_phase_select_q;
   reg clock_idle_polarity_q;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         master_mode_enable_q <= RESET_VALUE[`MASTER_BIT];
         clock_phase_select_q <= RESET_VALUE[`PHASE_BIT];
         clock_idle_polarity_q <= RESET_VALUE[`POL_BIT];
      end else if (sfr_wr && sfr_addr == `CFG_ADDR) begin
         master_mode_enable_q <= sfr_wdata[`MASTER_BIT];
         clock_phase_select_q <= sfr_wdata[`PHASE_BIT];
         clock_idle_polarity_q <= sfr_wdata[`POL_BIT];
      end
   end

   wire is_master = port_enable_bit & master_mode_enable_q;
   wire is_slave = port_enable_bit & ~master_mode_enable_q;
   wire slave_active = is_slave & ~sel_n_s;

   // ----------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------
   reg [7:0] tx_buf_q;
   reg [7:0] tx_sr_q;
   reg [7:0] rx_sr_q;
   reg [3:0] edge_cnt_q;
   reg [7:0] div_q;
   reg busy_q;
   reg sr_loaded_q;
   wire rx_in_ready;
   reg rx_push;
   reg [7:0] rx_next;

   assign sdo_out = tx_sr_q[7];

   wire div_end = (div_q == HALF_DIV - 1);
   wire m_edge = is_master & busy_q & div_end;
   wire s_edge = slave_active & (sck_s != sck_prev_q);
   wire edge_evt = m_edge | s_edge;
   // A leading edge leaves the idle level.
   wire leading = m_edge ? (sck_out_q == clock_idle_polarity_q)
                         : (sck_prev_q == clock_idle_polarity_q);
   wire sample_edge = leading ^ clock_phase_select_q;
   wire sdi = is_master ? miso_s : mosi_s;
   wire last_edge = (edge_cnt_q == `EDGES_PER_BYTE - 1);
   // The master waits for room in the receive buffer so no byte is lost.
   wire m_start = is_master & ~busy_q & ~tx_ready_q & rx_in_ready;

   always @* begin
      rx_next = sample_edge ? {rx_sr_q[6:0], sdi} : rx_sr_q;
      rx_push = edge_evt & last_edge;
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_buf_q <= 8'h00;
         tx_ready_q <= 1'b1;
         tx_sr_q <= 8'h00;
         rx_sr_q <= 8'h00;
         edge_cnt_q <= 4'h0;
         div_q <= 8'h00;
         busy_q <= 1'b0;
         sr_loaded_q <= 1'b0;
         sck_out_q <= 1'b0;
      end else begin
         if (tx_valid && tx_ready_q) begin
            tx_buf_q <= tx_data;
            tx_ready_q <= 1'b0;
         end
         if (!port_enable_bit || (is_slave && sel_n_s)) begin
            edge_cnt_q <= 4'h0;
            busy_q <= 1'b0;
            div_q <= 8'h00;
         end
         if (!busy_q) begin
            sck_out_q <= clock_idle_polarity_q;
         end
         if (m_start) begin
            tx_sr_q <= tx_buf_q;
            tx_ready_q <= 1'b1;
            sr_loaded_q <= 1'b1;
            busy_q <= 1'b1;
            edge_cnt_q <= 4'h0;
            div_q <= 8'h00;
         end else if (is_slave && !sr_loaded_q && !tx_ready_q &&
                      !edge_evt) begin
            // Never on an edge: the shift on that edge would win.
            tx_sr_q <= tx_buf_q;
            tx_ready_q <= 1'b1;
            sr_loaded_q <= 1'b1;
         end
         if (is_master && busy_q) begin
            div_q <= div_end ? 8'h00 : div_q + 8'h01;
            if (div_end) begin
               sck_out_q <= ~sck_out_q;
            end
         end
         if (edge_evt) begin
            rx_sr_q <= rx_next;
            if (!sample_edge &&
                !(clock_phase_select_q && edge_cnt_q == 4'h0)) begin
               tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            end
            edge_cnt_q <= edge_cnt_q + 4'h1;
            busy_q <= ~last_edge;
            if (last_edge) begin
               sr_loaded_q <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive buffer
   // ----------------------------------------------------------------
   // An overrun drops the new byte; flagging it is done elsewhere.
   byte_buffer #(
      .WIDTH(8)
   ) rx_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_data(rx_next),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   // ----------------------------------------------------------------
   // Pin enables and status read
   // ----------------------------------------------------------------
   reg [7:0] status;
   always @* begin
      status = 8'h00;
      status[`BUSY_BIT] = busy_q;
      status[`MASTER_BIT] = master_mode_enable_q;
      status[`PHASE_BIT] = clock_phase_select_q;
      status[`POL_BIT] = clock_idle_polarity_q;
      status[`SELECTED_BIT] = ~sel_n_s;
      status[`PIN_BIT] = sel_n_s;
      status[`SHIFT_EMPTY_BIT] = ~sr_loaded_q & tx_ready_q;
      // Meaningful only for a slave.
      status[`RX_EMPTY_BIT] = master_mode_enable_q | ~rx_valid;
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sfr_rdata_q <= 8'h00;
         sck_oe_q <= 1'b0;
         mosi_oe_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         sck_oe_q <= is_master;
         mosi_oe_q <= is_master;
         miso_oe_q <= slave_active;
         if (sfr_rd) begin
            sfr_rdata_q <= (sfr_addr == `CFG_ADDR) ? status : 8'h00;
         end
      end
   end
endmodule

// >>> serial_port_sva.sv
// Checker for the serial port unit.
// Assumes a bind to serial_port_unit.
`timescale 1ns/10ps
module serial_port_sva #(
   parameter HALF_DIV = 4
) (
   input wire mclk,
   input wire rst,
   input wire [7:0] sfr_addr,
   input wire sfr_rd,
   input wire [7:0] sfr_rdata_q,
   input wire tx_valid,
   input wire tx_ready_q,
   input wire [7:0] rx_data,
   input wire rx_valid,
   input wire rx_ready,
   input wire sel_n_in,
   input wire sck_out_q,
   input wire sck_oe_q,
   input wire mosi_oe_q,
   input wire miso_oe_q
);
   // ------
   // Checks
   // ------
   wire rd_cfg = sfr_rd && sfr_addr == 8'hA1;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_refused_read:
      assert property (sfr_rd && !rd_cfg |=> sfr_rdata_q == 8'h00)
      else $error("bad read");
   a_rx_empty_bit:
      assert property (rd_cfg && !rx_valid |=> sfr_rdata_q[0])
      else $error("rx empty");
   a_select_flags:
      assert property ($stable(sel_n_in)[*4] ##0 rd_cfg |=>
         sfr_rdata_q[3:2] == {!$past(sel_n_in), $past(sel_n_in)})
      else $error("select");
   a_idle_polarity:
      assert property (rd_cfg |=> sfr_rdata_q[7:6] != 2'h1 ||
         sfr_rdata_q[4] == $past(sck_out_q))
      else $error("idle");
   a_tx_taken:
      assert property (tx_valid && tx_ready_q |=> !tx_ready_q)
      else $error("tx");
   a_rx_held:
      assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("rx");
   a_master_drives:
      assert property (mosi_oe_q |-> sck_oe_q && !miso_oe_q)
      else $error("oe");
   a_half_period:
      assert property (sck_oe_q && $changed(sck_out_q) |=>
         $stable(sck_out_q)[*3])
      else $error("sck");
   cover property (rd_cfg && !sel_n_in);
   cover property (mosi_oe_q && $changed(sck_out_q));
   cover property (rx_valid && rx_ready);
endmodule
bind serial_port_unit serial_port_sva #(.HALF_DIV(HALF_DIV)) u_sva (
   .mclk, .rst, .sfr_addr, .sfr_rd, .sfr_rdata_q, .tx_valid, .tx_ready_q,
   .rx_data, .rx_valid, .rx_ready, .sel_n_in, .sck_out_q, .sck_oe_q,
   .mosi_oe_q, .miso_oe_q);

// >>> spi_far_end.sv
// Far end: slave to the unit as master, master to it as slave.
// Assumes phase 0, polarity 0 and lines resolved by the bench.
`timescale 1ns/10ps
module spi_far_end (
   input wire sck_line,
   input wire mosi_line,
   input wire miso_line,
   output reg sck_drv = 1'h0,
   output reg sel_n = 1'h1,
   output reg mosi_drv = 1'h0,
   output wire miso_drv
);
   reg [7:0] s_tx = 8'h00;
   reg [7:0] s_rx = 8'h00;
   // ----
   // Link
   // ----
   // Spent bits refill inverted, so a stale line never looks valid.
   assign miso_drv = s_tx[7];
   always @(posedge sck_line) if (sel_n) s_rx <= {s_rx[6:0], mosi_line};
   always @(negedge sck_line) if (sel_n) s_tx <= {s_tx[6:0], ~s_tx[7]};
   task send(input [7:0] b, output [7:0] r);
      integer i;
      begin
         sel_n = 1'h0;
         #200;
         for (i = 7; i >= 0; i = i - 1) begin
            mosi_drv = b[i];
            #62.5 sck_drv = 1'h1;
            r = {r[6:0], miso_line};
            #62.5 sck_drv = 1'h0;
         end
         #200 sel_n = 1'h1;
         mosi_drv = ~mosi_drv;
      end
   endtask
endmodule

// >>> test_serial_port_unit.sv
// Self-checking bench for serial_port_unit.
// Assumes the checker and spi_far_end are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin \
   err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module test_serial_port_unit;
   reg mclk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, rd_seen = 1'h0;
   reg port_enable_bit = 1'h0, tx_valid = 1'h0, rx_ready = 1'h1;
   reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tx_data = 8'h00;
   reg [7:0] b, c, r, ev, mv;
   wire [7:0] sfr_rdata_q, rx_data;
   wire tx_ready_q, rx_valid, sck_out_q, sck_oe_q, sdo_out, mosi_oe_q;
   wire miso_oe_q, far_sck, sel_n, far_mosi, far_miso;
   wire sck_w = sck_oe_q ? sck_out_q : far_sck;
   wire mosi_w = mosi_oe_q ? sdo_out : far_mosi;
   wire miso_w = miso_oe_q ? sdo_out : far_miso;
   integer err_count = 0, n_compared = 0, i;
   logic [7:0] exp_q[$], msk_q[$], rx_q[$];
   serial_port_unit #(.HALF_DIV(4)) u_serial_port_unit (.mclk, .rst,
      .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q,
      .port_enable_bit, .tx_data, .tx_valid, .tx_ready_q, .rx_data,
      .rx_valid, .rx_ready, .sck_in(sck_w), .sck_out_q, .sck_oe_q,
      .sel_n_in(sel_n), .mosi_in(mosi_w), .miso_in(miso_w), .sdo_out,
      .mosi_oe_q, .miso_oe_q);
   spi_far_end u_spi_far_end (.sck_line(sck_w), .mosi_line(mosi_w),
      .miso_line(miso_w), .sck_drv(far_sck), .sel_n, .mosi_drv(far_mosi),
      .miso_drv(far_miso));
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) rd_seen <= sfr_rd;
   always @(negedge mclk) begin
      if (rd_seen) begin
         mv = msk_q.pop_front();
         ev = exp_q.pop_front();
         `CHK("status", ev, sfr_rdata_q & mv)
      end
      if (rx_valid && rx_ready) begin
         ev = rx_q.pop_front();
         `CHK("rx_data", ev, rx_data)
      end
   end
   task acc(input w, input [7:0] a, input [7:0] d, input [7:0] m);
      begin
         @(posedge mclk);
         sfr_addr <= a;
         sfr_wdata <= d;
         sfr_wr <= w;
         sfr_rd <= !w;
         if (!w) exp_q.push_back(d & m);
         if (!w) msk_q.push_back(m);
         @(posedge mclk);
         sfr_wr <= 1'h0;
         sfr_rd <= 1'h0;
      end
   endtask
   task send_tx(input [7:0] d);
      begin
         @(posedge mclk);
         tx_data <= d;
         tx_valid <= 1'h1;
         @(posedge mclk);
         tx_valid <= 1'h0;
      end
   endtask
   task end_sim;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      #100000;
      err_count++;
      end_sim;
   end
   initial begin
      void'($urandom(93));
      repeat (8) @(posedge mclk);
      rst <= 1'h0;
      port_enable_bit <= 1'h1;
      acc(0, 8'hA1, 8'h07, 8'hFF);
      acc(0, 8'h55, 8'h00, 8'hFF);
      acc(1, 8'h55, 8'hFF, 8'h00);
      acc(0, 8'hA1, 8'h07, 8'hFF);
      for (i = 0; i < 4; i++) begin
         acc(1, 8'hA1, {2'h1, i[1:0], 4'hF}, 8'h00);
         acc(0, 8'hA1, {2'h1, i[1:0], 4'h7}, 8'hFF);
         repeat (2) @(posedge mclk);
         `CHK("idle sck", i[0], sck_out_q)
      end
      $display("test config done");
      acc(1, 8'hA1, 8'h40, 8'h00);
      // The idle clock falls one edge after the write; let it settle.
      repeat (2) @(posedge mclk);
      b = 8'($urandom);
      u_spi_far_end.s_tx = 8'($urandom);
      rx_q.push_back(u_spi_far_end.s_tx);
      send_tx(b);
      repeat (6) @(posedge mclk);
      acc(0, 8'hA1, 8'hC1, 8'hC1);
      repeat (80) @(posedge mclk);
      `CHK("far rx", b, u_spi_far_end.s_rx)
      acc(0, 8'hA1, 8'h47, 8'hFF);
      $display("test master done");
      acc(1, 8'hA1, 8'h00, 8'h00);
      b = 8'($urandom);
      c = 8'($urandom);
      rx_ready <= 1'h0;
      send_tx(b);
      rx_q.push_back(c);
      fork
         u_spi_far_end.send(c, r);
         begin
            #600;
            acc(0, 8'hA1, 8'h88, 8'hFC);
         end
      join
      repeat (3) @(posedge mclk);
      acc(0, 8'hA1, 8'h04, 8'h0D);
      rx_ready <= 1'h1;
      `CHK("far rx", b, r)
      acc(0, 8'hA1, 8'h01, 8'h01);
      $display("test slave done");
      end_sim;
   end
endmodule
